// File: logic/fcdo_pkg.sv
// Package for the flash clock divider and options block.
// Assumes a byte-wide register port and a 50 MHz bus clock.
package fcdo_pkg;
	// Register byte addresses
	localparam logic [3:0] FCDO_ADDR_DIV    = 4'h0;
	localparam logic [3:0] FCDO_ADDR_OPT    = 4'h1;
	localparam logic [3:0] FCDO_ADDR_CFG    = 4'h2;
	localparam logic [3:0] FCDO_ADDR_STAT   = 4'h3;
	localparam logic [3:0] FCDO_ADDR_MASK   = 4'h4;
	localparam logic [3:0] FCDO_ADDR_KEY0   = 4'h8;
	// Divider register fields
	localparam int         FCDO_DIV_LOADED  = 7;
	localparam int         FCDO_DIV_PRE8    = 6;
	localparam int         FCDO_DIV_VAL_W   = 6;
	localparam logic [7:0] FCDO_DIV_RESET   = 8'h00;
	localparam logic [2:0] FCDO_PRE_LAST    = 3'h7;
	// Options register fields
	localparam int         FCDO_OPT_BACKDOOR_ENABLE   = 7;
	localparam int         FCDO_OPT_NORED   = 6;
	localparam logic [7:0] FCDO_OPT_USED    = 8'hC3;
	localparam logic [7:0] FCDO_OPT_RESET   = 8'h03;
	localparam logic [1:0] FCDO_SEC_OPEN    = 2'h2;
	// Configuration register fields
	localparam int         FCDO_CFG_KEY_ACCESS_ENABLE  = 5;
	localparam logic [7:0] FCDO_CFG_USED    = 8'hE0;
	localparam logic [7:0] FCDO_CFG_RESET   = 8'h00;
	// Event status bits
	localparam int         FCDO_EV_ACCERR   = 0;
	localparam int         FCDO_EV_DONE     = 1;
	localparam int         FCDO_EV_UNLOCK   = 2;
	localparam int         FCDO_EV_W        = 3;
	localparam logic [2:0] FCDO_EV_RESET    = 3'h0;
	localparam int         FCDO_KEY_BYTES   = 8;
	localparam logic [3:0] FCDO_KEY_FULL    = 4'h8;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
		logic       from_debug;
		logic       from_secure;
	} fcdo_bus_t;

	typedef struct packed {
		logic       start;
		logic [7:0] pulses;
	} fcdo_cmd_t;

	// Only code 1:0 releases security
	function automatic logic fcdo_is_open(input logic [1:0] code);
		return code == FCDO_SEC_OPEN;
	endfunction : fcdo_is_open
endpackage : fcdo_pkg

// File: logic/fcdo_top.sv
// Flash clock divider, options, backdoor key and security gate.
// Assumes synchronous inputs on mclk, one-cycle strobes, read data a cycle later.
`timescale 1ns/1ps
module fcdo_top
	import fcdo_pkg::*;
(
	input  wire logic              mclk,
	input  wire logic              rstn,
	input  wire fcdo_pkg::fcdo_bus_t bus,
	output logic [7:0]             reg_rdata,
	input  wire logic [7:0]        nonvolatile_options_byte,
	input  wire logic [63:0]       stored_backdoor_key,
	input  wire fcdo_pkg::fcdo_cmd_t cmd,
	input  wire logic              blank_check_done,
	input  wire logic              blank_check_erased,
	input  wire logic              mem_req,
	input  wire logic              mem_from_unsecured,
	output logic                   mem_blocked,
	output logic                   flash_clk_tick,
	output logic                   prog_erase_enable,
	output logic                   op_busy,
	output logic                   secure,
	output logic                   backdoor_enable,
	output logic                   vector_redirect_disable,
	output logic                   irq
);
	import fcdo_pkg::*;

	logic [7:0]                flash_clock_divider;
	logic [7:0]                flash_options;
	logic                      opt_loaded;
	logic [1:0]                security_state_code;
	logic [7:0]                cfg;
	logic [FCDO_EV_W-1:0]      status;
	logic [FCDO_EV_W-1:0]      mask;
	logic [FCDO_EV_W-1:0]      ev_set;
	logic [FCDO_EV_W-1:0]      ev_clr;
	logic [2:0]                pre_cnt;
	logic [FCDO_DIV_VAL_W-1:0] div_cnt;
	logic                      pre_tick;
	logic                      next_tick;
	logic [7:0]                pulses_left;
	logic [3:0]                key_idx;
	logic                      key_ok;
	logic                      key_unlock;
	logic                      wr_div;
	logic                      wr_cfg;
	logic                      key_wr;
	logic                      divisor_loaded_flag;
	logic                      key_access_enable;

	assign divisor_loaded_flag = flash_clock_divider[FCDO_DIV_LOADED];
	assign key_access_enable   = cfg[FCDO_CFG_KEY_ACCESS_ENABLE];
	assign wr_div = bus.wr && bus.addr == FCDO_ADDR_DIV;
	assign wr_cfg = bus.wr && bus.addr == FCDO_ADDR_CFG;
	assign key_wr = bus.wr && bus.addr >= FCDO_ADDR_KEY0 && key_access_enable;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flash_clock_divider <= FCDO_DIV_RESET;
		end else if (wr_div && !divisor_loaded_flag) begin
			flash_clock_divider <= {1'b1, bus.wdata[6:0]};
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			opt_loaded    <= 1'b0;
			flash_options <= FCDO_OPT_RESET;
		end else if (!opt_loaded) begin
			opt_loaded    <= 1'b1;
			flash_options <= nonvolatile_options_byte & FCDO_OPT_USED;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			security_state_code <= FCDO_OPT_RESET[1:0];
		end else if (!opt_loaded) begin
			security_state_code <= nonvolatile_options_byte[1:0];
		end else if (key_unlock || (blank_check_done && blank_check_erased)) begin
			security_state_code <= FCDO_SEC_OPEN;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cfg <= FCDO_CFG_RESET;
		end else if (wr_cfg) begin
			cfg <= bus.wdata & FCDO_CFG_USED;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			key_idx <= 4'h0;
			key_ok  <= 1'b1;
		end else if (!key_access_enable) begin
			key_idx <= 4'h0;
			key_ok  <= 1'b1;
		end else if (key_wr && !bus.from_debug && bus.from_secure) begin
			if (key_idx < FCDO_KEY_FULL) begin
				key_idx <= key_idx + 4'h1;
			end
			if (bus.addr[2:0] != key_idx[2:0] || key_idx == FCDO_KEY_FULL
				|| bus.wdata != stored_backdoor_key[63 - 8*key_idx[2:0] -: 8]) begin
				key_ok <= 1'b0;
			end
		end
	end

	// Match takes effect when key access closes
	assign key_unlock = wr_cfg && key_access_enable && !bus.wdata[FCDO_CFG_KEY_ACCESS_ENABLE]
		&& key_ok && key_idx == FCDO_KEY_FULL && flash_options[FCDO_OPT_BACKDOOR_ENABLE];

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pre_cnt <= 3'h0;
		end else begin
			pre_cnt <= pre_cnt + 3'h1;
		end
	end

	assign pre_tick = !flash_clock_divider[FCDO_DIV_PRE8] || pre_cnt == FCDO_PRE_LAST;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			div_cnt <= '0;
		end else if (pre_tick) begin
			div_cnt <= next_tick ? '0 : div_cnt + 1'b1;
		end
	end

	assign next_tick = pre_tick && div_cnt == flash_clock_divider[FCDO_DIV_VAL_W-1:0];

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			flash_clk_tick <= 1'b0;
		end else begin
			flash_clk_tick <= next_tick;
		end
	end

	// Operation counted in whole flash clock pulses
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			op_busy     <= 1'b0;
			pulses_left <= 8'h00;
		end else if (!op_busy) begin
			if (cmd.start && divisor_loaded_flag && cmd.pulses != 8'h00) begin
				op_busy     <= 1'b1;
				pulses_left <= cmd.pulses;
			end
		end else if (flash_clk_tick) begin
			pulses_left <= pulses_left - 8'h01;
			if (pulses_left == 8'h01) begin
				op_busy <= 1'b0;
			end
		end
	end

	// Events; a set beats a clear in the same cycle
	always_comb begin
		ev_set = '0;
		ev_set[FCDO_EV_ACCERR] = cmd.start && !op_busy && !divisor_loaded_flag;
		ev_set[FCDO_EV_DONE]   = op_busy && flash_clk_tick && pulses_left == 8'h01;
		ev_set[FCDO_EV_UNLOCK] = key_unlock;
		ev_clr = (bus.wr && bus.addr == FCDO_ADDR_STAT) ? bus.wdata[FCDO_EV_W-1:0] : '0;
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			status <= FCDO_EV_RESET;
		end else begin
			status <= (status & ~ev_clr) | ev_set;
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			mask <= FCDO_EV_RESET;
		end else if (bus.wr && bus.addr == FCDO_ADDR_MASK) begin
			mask <= bus.wdata[FCDO_EV_W-1:0];
		end
	end

	// Lags status by one cycle to keep the output registered
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			secure                  <= 1'b1;
			mem_blocked             <= 1'b0;
			prog_erase_enable       <= 1'b0;
			backdoor_enable         <= 1'b0;
			vector_redirect_disable <= 1'b0;
		end else begin
			secure                  <= !fcdo_is_open(security_state_code);
			mem_blocked             <= mem_req && mem_from_unsecured
				&& !fcdo_is_open(security_state_code);
			prog_erase_enable       <= divisor_loaded_flag;
			backdoor_enable         <= flash_options[FCDO_OPT_BACKDOOR_ENABLE];
			vector_redirect_disable <= flash_options[FCDO_OPT_NORED];
		end
	end

	// Read port; unmapped and key addresses read zero
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata <= 8'h00;
		end else if (bus.rd) begin
			unique case (bus.addr)
				FCDO_ADDR_DIV:  reg_rdata <= flash_clock_divider;
				FCDO_ADDR_OPT:  reg_rdata <= {flash_options[7:2] & 6'h30,
					security_state_code};
				FCDO_ADDR_CFG:  reg_rdata <= cfg;
				FCDO_ADDR_STAT: reg_rdata <= {5'h00, status};
				FCDO_ADDR_MASK: reg_rdata <= {5'h00, mask};
				default:        reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	AST_DIV_ONCE: assert property (@(posedge mclk) disable iff (!rstn)
		divisor_loaded_flag && wr_div |=> $stable(flash_clock_divider))
		else $error("divider changed after first write");

	AST_LOADED_SET: assert property (@(posedge mclk) disable iff (!rstn)
		!divisor_loaded_flag && wr_div |=> divisor_loaded_flag
			&& flash_clock_divider[6:0] == $past(bus.wdata[6:0]))
		else $error("first divider write not taken");

	AST_CMD_REFUSED: assert property (@(posedge mclk) disable iff (!rstn)
		cmd.start && !op_busy && !divisor_loaded_flag |=> !op_busy
			&& status[FCDO_EV_ACCERR])
		else $error("command before divider load not refused");

	// Tick must come from a period already run with the prescaler on
	AST_PRESCALE: assert property (@(posedge mclk) disable iff (!rstn)
		flash_clk_tick && flash_clock_divider[FCDO_DIV_PRE8]
			&& $past(flash_clock_divider[FCDO_DIV_PRE8]) |=> !flash_clk_tick [*7])
		else $error("prescaled tick too early");

	AST_DIV_ZERO: assert property (@(posedge mclk) disable iff (!rstn)
		flash_clk_tick && flash_clock_divider[6:0] == 7'h00 |=> flash_clk_tick)
		else $error("divide by one missed a tick");

	AST_OPT_RO: assert property (@(posedge mclk) disable iff (!rstn)
		opt_loaded && bus.rd && bus.addr == FCDO_ADDR_OPT |=> reg_rdata[5:2] == 4'h0
			&& reg_rdata[7:6] == flash_options[7:6])
		else $error("options read wrong");

	AST_BLOCK: assert property (@(posedge mclk) disable iff (!rstn)
		mem_req && mem_from_unsecured && secure && $stable(security_state_code)
			|=> mem_blocked)
		else $error("unsecured access not blocked");

	AST_NO_BACKDOOR_ENABLE: assert property (@(posedge mclk) disable iff (!rstn)
		opt_loaded && !flash_options[FCDO_OPT_BACKDOOR_ENABLE] && !blank_check_done
			|=> $stable(security_state_code))
		else $error("security released with backdoor disabled");

	AST_DEBUG_KEY: assert property (@(posedge mclk) disable iff (!rstn)
		key_wr && bus.from_debug && key_access_enable |=> $stable(key_idx))
		else $error("debug key write accepted");

	AST_OP_DONE: assert property (@(posedge mclk) disable iff (!rstn)
		op_busy && flash_clk_tick && pulses_left == 8'h01 |=> !op_busy
			&& status[FCDO_EV_DONE])
		else $error("operation did not end on last pulse");

	AST_CMD_TAKEN: assert property (@(posedge mclk) disable iff (!rstn)
		cmd.start && !op_busy && divisor_loaded_flag && cmd.pulses != 8'h00 |=> op_busy)
		else $error("accepted command did not start");

	AST_NO_OP_UNLOADED: assert property (@(posedge mclk) disable iff (!rstn)
		!divisor_loaded_flag |-> !op_busy)
		else $error("operation running before divider load");

	AST_PE_ENABLE: assert property (@(posedge mclk) disable iff (!rstn)
		divisor_loaded_flag |=> prog_erase_enable)
		else $error("program and erase not enabled after load");

	AST_PULSE_HOLD: assert property (@(posedge mclk) disable iff (!rstn)
		op_busy && !flash_clk_tick |=> $stable(pulses_left))
		else $error("pulse count moved without a flash clock tick");

	AST_OPT_LOAD: assert property (@(posedge mclk) disable iff (!rstn)
		!opt_loaded |=> flash_options
			== ($past(nonvolatile_options_byte) & FCDO_OPT_USED))
		else $error("options byte not loaded after reset");

	AST_SEC_DECODE: assert property (@(posedge mclk) disable iff (!rstn)
		opt_loaded |=> secure == ($past(security_state_code) != FCDO_SEC_OPEN))
		else $error("security code decoded wrong");

	AST_UNSEC_FREE: assert property (@(posedge mclk) disable iff (!rstn)
		mem_req && !mem_from_unsecured |=> !mem_blocked)
		else $error("secure source access blocked");

	AST_KEY_OPEN: assert property (@(posedge mclk) disable iff (!rstn)
		key_unlock |=> security_state_code == FCDO_SEC_OPEN)
		else $error("key match did not release security");

	AST_BLANK_OPEN: assert property (@(posedge mclk) disable iff (!rstn)
		opt_loaded && blank_check_done && blank_check_erased
			|=> security_state_code == FCDO_SEC_OPEN)
		else $error("blank flash did not release security");
endmodule : fcdo_top

// File: tb/fcdo_nvm.sv
// Flash-side model: options byte, stored key and blank check answer.
// Assumes one go pulse per check; answers after lat cycles.
`timescale 1ns/1ps
module fcdo_nvm (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [7:0]  opt,
	input  wire logic [63:0] key_in,
	input  wire logic        go,
	input  wire logic        erased,
	input  wire logic [3:0]  lat,
	output logic [7:0]       nv_byte,
	output logic [63:0]      key,
	output logic             done,
	output logic             done_erased
);
	int cnt;
	assign nv_byte = opt;
	assign key = key_in;
	// blank check verdict
	// Verdict only valid with done; inverse otherwise
	assign done_erased = done ? erased : ~erased;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt <= 0;
			done <= 1'b0;
		end else if (go) begin
			cnt <= int'(lat);
			done <= 1'b0;
		end else if (cnt > 1) begin
			cnt <= cnt - 1;
		end else begin
			done <= (cnt == 1);
			cnt <= 0;
		end
	end
endmodule : fcdo_nvm

// File: tb/fcdo_top_test.sv
// Bench for fcdo_top: registers, command gate, key, security.
// Assumes fcdo_nvm as the flash side.
`timescale 1ns/1ps
module fcdo_top_test;
	import fcdo_pkg::*;
	logic        mclk, rstn, mem_req, mem_unsec, bgo, erased, bdone, berased;
	logic        blocked, tick, pe, busy, sec, bke, nored, irq;
	fcdo_bus_t   bus;
	fcdo_cmd_t   cmd;
	logic [7:0]  rdata, nvo, nvb, o, e, d;
	logic [63:0] key, nvk;
	logic [31:0] r;
	logic [3:0]  lat;
	int          miscompares, checked, seed, n;
	fcdo_top uut (.mclk(mclk), .rstn(rstn), .bus(bus), .reg_rdata(rdata),
		.nonvolatile_options_byte(nvb), .stored_backdoor_key(nvk), .cmd(cmd),
		.blank_check_done(bdone), .blank_check_erased(berased), .mem_req(mem_req),
		.mem_from_unsecured(mem_unsec), .mem_blocked(blocked), .flash_clk_tick(tick),
		.prog_erase_enable(pe), .op_busy(busy), .secure(sec), .backdoor_enable(bke),
		.vector_redirect_disable(nored), .irq(irq));
	fcdo_nvm nvm (.mclk(mclk), .rstn(rstn), .opt(nvo), .key_in(key), .go(bgo),
		.erased(erased), .lat(lat), .nv_byte(nvb), .key(nvk), .done(bdone),
		.done_erased(berased));
	task automatic chk(input string nm, input logic [63:0] x, input logic [63:0] g);
		checked++;
		if (g !== x) begin
			miscompares++;
			$display("wrong value %s expected %0h seen %0h", nm, x, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] v, input logic g);
		@(posedge mclk);
		bus <= '{a, v, 1'b1, 1'b0, g, ~g};
		@(posedge mclk);
		bus.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] x);
		@(posedge mclk);
		bus <= '{a, 8'h00, 1'b0, 1'b1, 1'b0, 1'b1};
		@(posedge mclk);
		bus.rd <= 1'b0;
		#1 chk("rdata", x, rdata);
	endtask : rd
	task automatic boot(input logic [7:0] v);
		@(posedge mclk);
		rstn <= 1'b0;
		nvo <= v;
		repeat (16) @(posedge mclk);
		rstn <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
	endtask : boot
	task automatic to_tick(output int c);
		c = 0;
		do begin
			@(posedge mclk);
			#1;
			c++;
		end while (tick !== 1'b1 && c < 600);
	endtask : to_tick
	task automatic start(input logic [7:0] p);
		@(posedge mclk);
		cmd <= '{1'b1, p};
		@(posedge mclk);
		cmd.start <= 1'b0;
	endtask : start
	task automatic mem(input logic b);
		@(posedge mclk);
		mem_req <= 1'b1;
		mem_unsec <= 1'b1;
		@(posedge mclk);
		mem_req <= 1'b0;
		#1 chk("blocked", b, blocked);
	endtask : mem
	task automatic keys(input logic g);
		wr(FCDO_ADDR_CFG, 8'h20, 1'b0);
		for (int i = 0; i < 8; i++) wr(FCDO_ADDR_KEY0 + 4'(i), key[63 - 8*i -: 8], g);
		wr(FCDO_ADDR_CFG, 8'h00, 1'b0);
		repeat (2) @(posedge mclk);
		#1;
	endtask : keys
	task automatic blank(input logic v);
		@(posedge mclk);
		erased <= v;
		bgo <= 1'b1;
		@(posedge mclk);
		bgo <= 1'b0;
		repeat (12) @(posedge mclk);
		#1;
	endtask : blank
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test
	initial begin
		mclk = 1'b0;
		forever #10 mclk = ~mclk;
	end
	// Whole run needs under two thousand cycles
	initial begin
		#200_000;
		miscompares++;
		finish_test;
	end
	initial begin
		seed = 73328;
		miscompares = 0;
		checked = 0;
		rstn = 1'b0;
		bus = '0;
		cmd = '0;
		mem_req = 1'b0;
		mem_unsec = 1'b0;
		bgo = 1'b0;
		erased = 1'b0;
		nvo = 8'h00;
		r = $random(seed);
		lat = 4'h1 + 4'(r[14:12]);
		key = {$random(seed), $random(seed)};
		for (int c = 0; c < 4; c++) begin
			boot({r[7:2], 2'(c)});
			chk("secure", c != 2, sec);
		end
		o = {1'b1, r[6:2], 2'b11};
		boot(o);
		e = {o[7:6], 4'h0, o[1:0]};
		rd(FCDO_ADDR_OPT, e);
		wr(FCDO_ADDR_OPT, ~e, 1'b0);
		rd(FCDO_ADDR_OPT, e);
		chk("bke", 1, bke);
		chk("nored", o[6], nored);
		mem(1'b1);
		start(8'h02);
		repeat (2) @(posedge mclk);
		#1 chk("busy", 0, busy);
		rd(FCDO_ADDR_STAT, 8'h01);
		wr(FCDO_ADDR_STAT, 8'h01, 1'b0);
		rd(FCDO_ADDR_STAT, 8'h00);
		to_tick(n);
		to_tick(n);
		chk("period", 1, n);
		// Flash clock 150 to 200 kHz from 50 MHz
		d = {2'b01, 6'h1F + 6'(r[11:9])};
		wr(FCDO_ADDR_DIV, d, 1'b0);
		rd(FCDO_ADDR_DIV, {1'b1, d[6:0]});
		wr(FCDO_ADDR_DIV, ~d, 1'b0);
		rd(FCDO_ADDR_DIV, {1'b1, d[6:0]});
		chk("enable", 1, pe);
		to_tick(n);
		to_tick(n);
		chk("period", (d[6] ? 8 : 1) * (d[5:0] + 1), n);
		wr(FCDO_ADDR_MASK, 8'h02, 1'b0);
		start(8'h02);
		n = 0;
		repeat (700) begin
			@(posedge mclk);
			#1;
			if (busy === 1'b1 && tick === 1'b1) n++;
		end
		chk("ticks", 2, n);
		chk("irq", 1, irq);
		rd(FCDO_ADDR_STAT, 8'h02);
		wr(FCDO_ADDR_STAT, 8'h02, 1'b0);
		repeat (2) @(posedge mclk);
		#1 chk("irq", 0, irq);
		keys(1'b1);
		chk("secure", 1, sec);
		keys(1'b0);
		chk("secure", 0, sec);
		chk("irq", 0, irq);
		rd(FCDO_ADDR_STAT, 8'h04);
		mem(1'b0);
		rd(FCDO_ADDR_OPT, {e[7:2], 2'b10});
		boot({1'b0, r[6:2], 2'b00});
		chk("secure", 1, sec);
		chk("bke", 0, bke);
		keys(1'b0);
		chk("secure", 1, sec);
		blank(1'b0);
		chk("secure", 1, sec);
		blank(1'b1);
		chk("secure", 0, sec);
		finish_test;
	end
endmodule : fcdo_top_test
